// *** rtl/wdt_defines.svh ***
// register offsets, field positions, reset values and counts of the watchdog
// assumes inclusion by the watchdog module only; the package does not include it
`ifndef WDT_DEFINES_SVH
`define WDT_DEFINES_SVH

`define ADDR_CLOCK_AND_INTERVAL_CONTROL 8'h8e
`define ADDR_WATCHDOG_CONTROL_STATUS 8'hd8
`define ADDR_UNLOCK_REGISTER 8'hc7

`define RESET_CLOCK_AND_INTERVAL_CONTROL 8'h03
`define RESET_WATCHDOG_CONTROL_STATUS 8'h00

`define UNLOCK_KEY_FIRST 8'haa
`define UNLOCK_KEY_SECOND 8'h55

`define BIT_INTERVAL_HI 7
`define BIT_INTERVAL_LO 6
`define BIT_CLOCK_MODE_HI 2
`define BIT_CLOCK_MODE_LO 0
`define BIT_TIMEOUT_IRQ_FLAG 3
`define BIT_RESET_CAUSE_FLAG 2
`define BIT_RESET_ENABLE 1
`define BIT_RESTART_STROBE 0

`define COUNT_WIDTH 27
`define INTERVAL_00_CLOCKS 27'd131072
`define INTERVAL_01_CLOCKS 27'd1048576
`define INTERVAL_10_CLOCKS 27'd8388608
`define INTERVAL_11_CLOCKS 27'd67108864
`define RESET_DELAY_CLOCKS 10'd512

`endif

// *** rtl/wdt_pkg.sv ***
// types shared by the watchdog and whoever drives its special function port
// assumes nothing beyond the defines header
package wdt_pkg;
   typedef enum logic [1:0] {
      UNLOCK_IDLE = 2'b00,
      UNLOCK_FIRST = 2'b01,
      UNLOCK_OPEN = 2'b10
   } unlock_state_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } sfr_req_t;

   typedef struct packed {
      logic timeout_irq_flag;
      logic reset_cause_flag;
      logic reset_enable;
      logic restart_strobe;
   } control_status_t;
endpackage

// *** rtl/watchdog_timer_with_reset.sv ***
// watchdog timer with timeout flag, delayed core reset and timed-access unlock
// assumes a core that drives one special function access per cycle and that
// rst carries every reset of the core except the one this block requests
`timescale 1ns/1ps
`include "wdt_defines.svh"

// How it works
// R1: timeout after 131072, 1048576, 8388608 or 67108864 clocks per interval field
// R2: interval field sits in bits 7 and 6 of clock control register
// R3: with reset enabled, core reset follows timeout by 512 clocks unless restarted
// R4: restart strobe clears the count so counting begins again from zero
// R5: restart strobe bit clears itself after one cycle
// R6: watchdog reset sets reset cause flag; only software or another reset clears it
// R7: software writing the cause flag to one stores status, no reset
// R8: any other reset clears the cause flag; otherwise it stays set
// R9: watchdog leaves the cause flag alone while reset enable is zero
// R10: reset enable gates the core reset only, never the interrupt
// R11: every timeout sets the irq flag; request needs both enables
// R12: with irq enable low, flag still sets so software can poll it
// R13: irq flag clears on software write of zero or on reset
// R14: watchdog keeps running through its own reset and restarts the count
// R15: counter runs free on the system clock with no extra prescaler
// R16: software unlocks every write of the watchdog control register
// R17: software should prefer the interrupt over the watchdog reset
// R18: unlock is 0xaa then 0x55 to the unlock register, then the write
// R19: software writing one to the irq flag raises the interrupt as a timeout would, without arming a reset
// R20: control writes without a fresh unlock are ignored entirely
module watchdog_timer_with_reset
   import wdt_pkg::*;
#(
   parameter logic [26:0] INTERVAL_00 = `INTERVAL_00_CLOCKS,
   parameter logic [26:0] INTERVAL_01 = `INTERVAL_01_CLOCKS,
   parameter logic [26:0] INTERVAL_10 = `INTERVAL_10_CLOCKS,
   parameter logic [26:0] INTERVAL_11 = `INTERVAL_11_CLOCKS
) (
   input wire logic clock,
   input wire logic rst,
   input wire sfr_req_t sfr_req,
   output logic [7:0] sfr_rdata,
   input wire logic timeout_irq_enable,
   input wire logic global_irq_enable,
   output logic timeout_irq_req,
   output logic mcu_reset
);

   // ************************************************************
   // constants
   // ************************************************************
   // reset images are kept whole so every field takes its value from one place
   localparam logic [7:0] INTERVAL_RESET = `RESET_CLOCK_AND_INTERVAL_CONTROL;
   localparam logic [7:0] CONTROL_RESET = `RESET_WATCHDOG_CONTROL_STATUS;
   localparam logic [9:0] DELAY_LAST = `RESET_DELAY_CLOCKS - 10'd1;

   // ************************************************************
   // shared state
   // ************************************************************
   // state and strobes that more than one section reads, and the count, read only by the counter
   control_status_t control_status;
   logic [1:0] interval_select;
   logic [26:0] count;
   logic restart_write;
   logic timeout_event;
   logic reset_fire;

   // ************************************************************
   // address decode
   // ************************************************************
   logic hit_unlock;
   logic hit_control;
   logic hit_interval;
   logic unlock_open;
   logic control_write;
   logic interval_write;

   assign hit_unlock = sfr_req.addr == `ADDR_UNLOCK_REGISTER;
   assign hit_control = sfr_req.addr == `ADDR_WATCHDOG_CONTROL_STATUS;
   assign hit_interval = sfr_req.addr == `ADDR_CLOCK_AND_INTERVAL_CONTROL;

   // interval selection needs no unlock; only the control register is guarded
   assign interval_write = sfr_req.wr & hit_interval;
   // only the write right after the two keys may touch the control register
   assign control_write = sfr_req.wr & hit_control & unlock_open; // R20

   // ************************************************************
   // timed-access unlock
   // ************************************************************
   unlock_state_t unlock_state;
   unlock_state_t next_unlock_state;
   logic key_first;
   logic key_second;

   assign key_first = sfr_req.wr & hit_unlock & (sfr_req.wdata == `UNLOCK_KEY_FIRST);
   assign key_second = sfr_req.wr & hit_unlock & (sfr_req.wdata == `UNLOCK_KEY_SECOND);
   assign unlock_open = unlock_state == UNLOCK_OPEN;

   // any write, matching or not, advances, restarts or closes the sequence; cycles
   // without a write leave it where it is
   always_comb begin
      next_unlock_state = unlock_state;
      if (sfr_req.wr) begin
         unique case (unlock_state)
            UNLOCK_IDLE: begin
               if (key_first) begin
                  next_unlock_state = UNLOCK_FIRST; // R18
               end else begin
                  next_unlock_state = UNLOCK_IDLE; // R20
               end
            end
            UNLOCK_FIRST: begin
               if (key_second) begin
                  next_unlock_state = UNLOCK_OPEN; // R18
               end else if (key_first) begin
                  next_unlock_state = UNLOCK_FIRST; // R18
               end else begin
                  next_unlock_state = UNLOCK_IDLE; // R20
               end
            end
            UNLOCK_OPEN: begin
               // the single protected write spends the unlock
               if (key_first) begin
                  next_unlock_state = UNLOCK_FIRST; // R18
               end else begin
                  next_unlock_state = UNLOCK_IDLE; // R20
               end
            end
            default: begin
               // the unused code falls back to closed
               next_unlock_state = UNLOCK_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         unlock_state <= UNLOCK_IDLE;
      end else begin
         unlock_state <= next_unlock_state;
      end
   end

   // ************************************************************
   // clock and interval control register
   // ************************************************************
   logic [1:0] next_interval_select;
   logic [2:0] clock_mode;
   logic [2:0] next_clock_mode;

   // the mode bits drive no logic and no port of this block; they are only kept here and read back
   always_comb begin
      next_interval_select = interval_select;
      next_clock_mode = clock_mode;
      if (interval_write) begin
         next_interval_select = sfr_req.wdata[`BIT_INTERVAL_HI:`BIT_INTERVAL_LO]; // R2
         next_clock_mode = sfr_req.wdata[`BIT_CLOCK_MODE_HI:`BIT_CLOCK_MODE_LO];
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         interval_select <= INTERVAL_RESET[`BIT_INTERVAL_HI:`BIT_INTERVAL_LO];
         clock_mode <= INTERVAL_RESET[`BIT_CLOCK_MODE_HI:`BIT_CLOCK_MODE_LO];
      end else begin
         interval_select <= next_interval_select;
         clock_mode <= next_clock_mode;
      end
   end

   // ************************************************************
   // interval limit
   // ************************************************************
   // limits are parameters so that simulation can shorten them
   logic [26:0] limit;

   always_comb begin
      unique case (interval_select)
         2'b00: limit = INTERVAL_00; // R1
         2'b01: limit = INTERVAL_01; // R1
         2'b10: limit = INTERVAL_10; // R1
         2'b11: limit = INTERVAL_11; // R1
      endcase
   end

   // ************************************************************
   // watchdog counter
   // ************************************************************
   logic [26:0] next_count;
   logic terminal;

   // compare with >= so a shorter interval chosen mid-count takes effect at once
   assign terminal = count >= (limit - 27'd1); // R1
   assign restart_write = control_write & sfr_req.wdata[`BIT_RESTART_STROBE]; // R4
   // a restart in the terminal cycle wins: no flag and no arming
   assign timeout_event = terminal & ~restart_write;

   // no prescaler: one count per clock, and the count never stops, not
   // even across the reset this block requests
   always_comb begin
      next_count = count + 27'd1; // R15
      if (restart_write || terminal || reset_fire) begin
         next_count = '0; // R4 R14
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         count <= '0;
      end else begin
         count <= next_count;
      end
   end

   // ************************************************************
   // reset delay
   // ************************************************************
   logic armed;
   logic next_armed;
   logic [9:0] delay;
   logic [9:0] next_delay;

   assign reset_fire = armed & control_status.reset_enable &
                       (delay == DELAY_LAST); // R3 R10

   // later timeouts while armed do not restart the delay, so the reset keeps
   // its place after the first missed restart
   always_comb begin
      next_armed = armed;
      next_delay = delay;
      if (restart_write) begin
         next_armed = 1'b0; // R3
         next_delay = '0;
      end else if (armed) begin
         if (!control_status.reset_enable || reset_fire) begin
            next_armed = 1'b0; // R10
            next_delay = '0;
         end else begin
            next_delay = delay + 10'd1;
         end
      end else if (timeout_event && control_status.reset_enable) begin
         next_armed = 1'b1; // R3 R10
         next_delay = '0;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         armed <= 1'b0;
         delay <= '0;
      end else begin
         armed <= next_armed;
         delay <= next_delay;
      end
   end

   // ************************************************************
   // core reset request
   // ************************************************************
   logic next_mcu_reset;

   // one registered cycle; a core that needs a longer reset stretches it itself
   always_comb begin
      next_mcu_reset = reset_fire; // R3
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         mcu_reset <= 1'b0;
      end else begin
         mcu_reset <= next_mcu_reset;
      end
   end

   // ************************************************************
   // watchdog control and status register
   // ************************************************************
   control_status_t next_control_status;

   always_comb begin
      next_control_status = control_status;
      next_control_status.restart_strobe = 1'b0; // R5
      if (control_write) begin
         // a written one only stores status and never starts a reset
         next_control_status.timeout_irq_flag =
            sfr_req.wdata[`BIT_TIMEOUT_IRQ_FLAG]; // R13 R19
         next_control_status.reset_cause_flag =
            sfr_req.wdata[`BIT_RESET_CAUSE_FLAG]; // R7
         next_control_status.reset_enable = sfr_req.wdata[`BIT_RESET_ENABLE]; // R10 R16
         next_control_status.restart_strobe = sfr_req.wdata[`BIT_RESTART_STROBE]; // R4
      end
      // hardware sets win over a software clear in the same cycle
      if (timeout_event) begin
         next_control_status.timeout_irq_flag = 1'b1; // R11 R12
      end
      // besides a software write of one, only the watchdog's own reset sets the cause;
      // with reset disabled it never fires, so the flag is left alone
      if (reset_fire) begin
         next_control_status.reset_cause_flag = 1'b1; // R6 R9
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         // every other reset of the core clears both flags and the enable
         control_status <= control_status_t'(
            CONTROL_RESET[`BIT_TIMEOUT_IRQ_FLAG:`BIT_RESTART_STROBE]); // R8 R13
      end else begin
         control_status <= next_control_status;
      end
   end

   // ************************************************************
   // interrupt request
   // ************************************************************
   // enable bit and global enable only gate the request, never the flag; a
   // flag left set keeps the request up, so software clears it before leaving
   assign timeout_irq_req = control_status.timeout_irq_flag & timeout_irq_enable &
                            global_irq_enable; // R11 R19

   // ************************************************************
   // read data
   // ************************************************************
   logic [7:0] next_sfr_rdata;

   // unmapped addresses and the unlock register read as zero, and so do
   // bits without storage
   always_comb begin
      next_sfr_rdata = 8'h00;
      if (sfr_req.rd) begin
         if (hit_control) begin
            next_sfr_rdata = {4'h0, control_status};
         end else if (hit_interval) begin
            next_sfr_rdata = {interval_select, 3'h0, clock_mode};
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         sfr_rdata <= 8'h00;
      end else begin
         sfr_rdata <= next_sfr_rdata;
      end
   end

endmodule // watchdog_timer_with_reset

// *** dv/core_reset_model.sv ***
// core side model: counts the watchdog reset pulses it is asked to act on
// assumes one clock; the pulse is never routed back into rst
`timescale 1ns/1ps
module core_reset_model (
   input wire logic clock,
   input wire logic mcu_reset,
   output int resets
);
   initial resets = 0;
   always @(posedge clock) if (mcu_reset) resets++;
endmodule // core_reset_model

// *** dv/wdt_props.sv ***
// port checker for the watchdog
// assumes binding onto the watchdog top module
`timescale 1ns/1ps
module wdt_props
   import wdt_pkg::*;
#(
   parameter logic [26:0] INTERVAL_00 = 27'd64,
   parameter logic [26:0] INTERVAL_01 = 27'd128,
   parameter logic [26:0] INTERVAL_10 = 27'd256,
   parameter logic [26:0] INTERVAL_11 = 27'd512
) (
   input wire logic clock,
   input wire logic rst,
   input wire sfr_req_t sfr_req,
   input wire logic [7:0] sfr_rdata,
   input wire logic timeout_irq_enable,
   input wire logic global_irq_enable,
   input wire logic timeout_irq_req,
   input wire logic mcu_reset
);
   // ****
   // properties
   // ****
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   // cycles since any core reset; a watchdog reset needs a full interval plus the delay
   logic [27:0] gap;
   logic [27:0] next_gap;
   logic ens;
   assign ens = timeout_irq_enable && global_irq_enable;
   always_comb next_gap = (rst || mcu_reset) ? 28'h0 : gap + 28'h1;
   always_ff @(posedge clock) gap <= next_gap;
   sequence unlock_s;
      sfr_req.wr && sfr_req.addr == 8'hc7 && sfr_req.wdata == 8'haa
      ##1 sfr_req.wr && sfr_req.addr == 8'hc7 && sfr_req.wdata == 8'h55;
   endsequence
   sequence ctl_wr_s;
      sfr_req.wr && sfr_req.addr == 8'hd8;
   endsequence
   irq_gate_a: assert property (timeout_irq_req |-> ens)
      else $error("irq without enables");
   reset_pulse_a: assert property (mcu_reset |=> !mcu_reset)
      else $error("reset pulse too long");
   reset_gap_a: assert property (mcu_reset |-> gap >= {1'b0, INTERVAL_00} + 28'd510)
      else $error("reset too early");
   idle_rdata_a: assert property ((!sfr_req.rd || sfr_req.addr == 8'hc7) |=> sfr_rdata == 8'h00)
      else $error("read data not idle");
   interval_hole_a: assert property (sfr_req.rd && sfr_req.addr == 8'h8e |=> sfr_rdata[5:3] == 3'h0)
      else $error("clock control hole set");
   gate_off_a: assert property (unlock_s ##1 (ctl_wr_s and !sfr_req.wdata[1]) |=> ##1 !mcu_reset [*8])
      else $error("reset while disabled");
   soft_irq_a: assert property (unlock_s ##1 (ctl_wr_s and sfr_req.wdata[3]) ##1 ens |-> timeout_irq_req)
      else $error("soft flag no request");
   irq_hold_a: assert property (timeout_irq_req && !(sfr_req.wr && sfr_req.addr == 8'hd8) ##1 ens |-> timeout_irq_req)
      else $error("irq flag dropped");
endmodule // wdt_props
bind watchdog_timer_with_reset wdt_props #(.INTERVAL_00(INTERVAL_00), .INTERVAL_01(INTERVAL_01),
   .INTERVAL_10(INTERVAL_10), .INTERVAL_11(INTERVAL_11)) wdt_props_i (.clock, .rst, .sfr_req,
   .sfr_rdata, .timeout_irq_enable, .global_irq_enable, .timeout_irq_req, .mcu_reset);

// *** dv/watchdog_timer_with_reset_tb.sv ***
// self-checking bench for the watchdog with shortened intervals
// assumes the core model only counts reset pulses
`timescale 1ns/1ps
module watchdog_timer_with_reset_tb;
   import wdt_pkg::*;
   // ****
   // bench
   // ****
   // shortened intervals handed to the design below, one per interval code
   function automatic int interval_clocks(input int sel);
      case (sel)
         0: return 64;
         1: return 128;
         2: return 256;
         default: return 512;
      endcase
   endfunction
   logic clock = 1'b0;
   logic rst = 1'b1;
   sfr_req_t sfr_req = '0;
   logic [7:0] sfr_rdata;
   logic timeout_irq_enable = 1'b0;
   logic global_irq_enable = 1'b0;
   logic timeout_irq_req;
   logic mcu_reset;
   wire logic ens = timeout_irq_enable & global_irq_enable;
   int resets;
   int error_cnt = 0;
   int total_checks = 0;
   int cyc = 0;
   int n;
   int r0;
   always #2.5 clock = ~clock;
   watchdog_timer_with_reset #(.INTERVAL_00(27'd64), .INTERVAL_01(27'd128),
      .INTERVAL_10(27'd256), .INTERVAL_11(27'd512)) watchdog_timer_with_reset_i (.clock, .rst,
      .sfr_req, .sfr_rdata, .timeout_irq_enable, .global_irq_enable, .timeout_irq_req,
      .mcu_reset);
   core_reset_model core_reset_model_i (.clock, .mcu_reset, .resets);
   task automatic complete_run;
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD %s exp %0h seen %0h", name, exp, seen);
      end
   endtask
   // writes hold wr high so that chained writes land back to back
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      sfr_req = '{1'b1, 1'b0, a, d};
      @(negedge clock);
   endtask
   task automatic put(input logic [7:0] a, input logic [7:0] d);
      wr(a, d);
      sfr_req.wr = 1'b0;
      @(negedge clock);
   endtask
   task automatic unlock(input logic [7:0] d);
      wr(8'hc7, 8'haa);
      wr(8'hc7, 8'h55);
      put(8'hd8, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      sfr_req = '{1'b0, 1'b1, a, 8'h00};
      @(negedge clock);
      chk("sfr_rdata", 32'(sfr_rdata), 32'(e));
      sfr_req.rd = 1'b0;
      @(negedge clock);
   endtask
   // on_reset picks the core reset pulse, otherwise the interrupt request
   task automatic wait_hi(input bit on_reset);
      n = 0;
      while ((on_reset ? mcu_reset : timeout_irq_req) !== 1'b1 && n < 2000) begin
         @(negedge clock);
         n++;
      end
   endtask
   always @(posedge clock) begin
      cyc++;
      if (cyc == 9000) begin
         error_cnt++;
         complete_run;
      end
   end
   initial begin
      void'($urandom(32'hc0dd63e8));
      repeat (4) @(negedge clock);
      rst = 1'b0;
      rd(8'h8e, 8'h03);
      rd(8'hc7, 8'h00);
      rd(8'h80 | 8'($urandom_range(0, 12)), 8'h00);
      timeout_irq_enable = 1'b1;
      global_irq_enable = 1'b1;
      for (int s = 0; s < 4; s++) begin
         put(8'h8e, {s[1:0], 6'h03});
         rd(8'h8e, {s[1:0], 6'h03});
         unlock(8'h01);
         wait_hi(1'b0);
         chk("interval", n, interval_clocks(s) - 1);
         timeout_irq_enable = 1'($urandom);
         global_irq_enable = 1'($urandom);
         @(negedge clock);
         chk("irq_req", 32'(timeout_irq_req), 32'(ens));
         rd(8'hd8, 8'h08);
         timeout_irq_enable = 1'b1;
         global_irq_enable = 1'b1;
      end
      put(8'h8e, 8'h03);
      unlock(8'h03);
      wait_hi(1'b0);
      wait_hi(1'b1);
      chk("reset_delay", n, 512);
      rd(8'hd8, 8'h0e);
      unlock(8'h03);
      wait_hi(1'b0);
      repeat (100) @(negedge clock);
      r0 = resets;
      unlock(8'h03);
      rd(8'hd8, 8'h02);
      repeat (530) @(negedge clock);
      chk("resets", resets, r0);
      unlock(8'h00);
      repeat (700) @(negedge clock);
      chk("resets", resets, r0);
      rd(8'hd8, 8'h08);
      unlock(8'h01);
      chk("irq_req", 32'(timeout_irq_req), 32'h0);
      unlock(8'h09);
      chk("irq_req", 32'(timeout_irq_req), 32'h1);
      unlock(8'h05);
      wr(8'hc7, 8'haa);
      wr(8'h8e, 8'h03);
      wr(8'hc7, 8'h55);
      put(8'hd8, 8'($urandom));
      rd(8'hd8, 8'h04);
      rst = 1'b1;
      @(negedge clock);
      rst = 1'b0;
      rd(8'hd8, 8'h00);
      chk("resets", resets, r0);
      complete_run;
   end
endmodule // watchdog_timer_with_reset_tb
